/* File: design/bss_monitor.sv */
`timescale 1ns/1ps
// Operation
// - count runs of adjacent pixels above threshold, compare with run preset
// - fire only after qualifying runs in consecutive frames, not single hits
// - pixel analysis starts at and is aligned to frame sync
// - detection drives cathode-safe output at once, without software
// - detection sets alert flag readable in status register
// - system enable starts monitoring at next integration-run sync
// - alert flag is sticky until explicitly cleared
// - cathode-safe set on detection only with alert enable set
// - alert reset clears cathode-safe, alert flag and detection logic
// - alert reset leaves thresholds and presets unchanged
// - alert enable gates only cathode path, flag independent of it
// - threshold readable and writable, only top five bits compared
// - run-length preset readable and writable, sets adjacent pixel count
// - frame-count preset readable and writable, sets consecutive frames
// - exactly two read/write addresses carry control and monitoring
// - response within tens of milliseconds, independent of software
// - control bus accesses run at 512 Hz bit rate; here each wishbone access is acked one clock after the request
// - every access to the two addresses is acknowledged
module bss_monitor import bss_pkg::*; #(
  parameter int PIX_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pix_valid_i,
  input wire logic [PIX_W-1:0] pix_i,
  input wire logic frame_sync_i,
  input wire logic integration_run_sync_i,
  output logic cathode_safe_o,
  output logic alert_flag_o,
  output logic monitor_active_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    bss_state_t st;
    logic sys_en;
    logic alert_en;
    logic alert_rst;
    logic [FIELD_W-1:0] thr;
    logic [FIELD_W-1:0] run_preset;
    logic [FIELD_W-1:0] frm_preset;
    logic frame_open;
    logic [FIELD_W-1:0] frame_cnt;
    logic alert_flag;
    logic cathode_safe;
    logic ack;
    logic [31:0] dat;
  } bss_mon_st_t;

  localparam bss_mon_st_t RESET_ST = '{
    st: BSS_IDLE,
    sys_en: 1'b0,
    alert_en: 1'b0,
    alert_rst: 1'b0,
    thr: THR_RST,
    run_preset: RUN_RST,
    frm_preset: FRM_RST,
    frame_open: 1'b0,
    frame_cnt: '0,
    alert_flag: 1'b0,
    cathode_safe: 1'b0,
    ack: 1'b0,
    dat: '0
  };

  bss_mon_st_t s;
  bss_mon_st_t next_s;

  logic det_clear;
  logic det_hit;
  logic frame_end;
  logic fire;
  logic [8:0] cnt_inc;
  logic wr_take;
  logic [31:0] ctrl_word;
  logic [31:0] pre_word;
  logic [31:0] ctrl_new;
  logic [31:0] pre_new;

  // ----------------------------------------------------------------
  // pixel run detector
  // ----------------------------------------------------------------
  assign det_clear = frame_sync_i || !(s.st == BSS_MON) || !s.frame_open || s.alert_rst;

  bss_run_detect #(
    .PIX_W(PIX_W)
  ) bss_run_detect_i (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(det_clear),
    .pix_valid_i(pix_valid_i),
    .pix_i(pix_i),
    .thr_i(s.thr),
    .preset_i(s.run_preset),
    .run_o(),
    .hit_o(det_hit)
  );

  // ----------------------------------------------------------------
  // register words
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_word = '0;
    ctrl_word[CTRL_SYS_EN] = s.sys_en;
    ctrl_word[CTRL_ALERT_EN] = s.alert_en;
    ctrl_word[CTRL_ALERT_RST] = s.alert_rst;
    ctrl_word[STAT_FLAG] = s.alert_flag;
    ctrl_word[STAT_CATHODE] = s.cathode_safe;
    ctrl_word[STAT_MONITOR] = (s.st == BSS_MON);
    ctrl_word[STAT_FCNT_LSB +: FIELD_W] = s.frame_cnt;
    pre_word = '0;
    pre_word[PRE_THR_LSB +: FIELD_W] = s.thr;
    pre_word[PRE_RUN_LSB +: FIELD_W] = s.run_preset;
    pre_word[PRE_FRM_LSB +: FIELD_W] = s.frm_preset;
    ctrl_new = bss_merge(ctrl_word, wb_dat_i, wb_sel_i);
    pre_new = bss_merge(pre_word, wb_dat_i, wb_sel_i);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    frame_end = frame_sync_i && (s.st == BSS_MON) && s.frame_open;
    cnt_inc = {1'b0, s.frame_cnt} + 9'h001;
    fire = frame_end && det_hit && !s.alert_rst && (cnt_inc >= {1'b0, s.frm_preset});
    wr_take = wb_cyc_i && wb_stb_i && wb_we_i && s.ack;

    // bus: answer one cycle after the request, drop the cycle after
    next_s.ack = wb_cyc_i && wb_stb_i && !s.ack;
    if (wb_cyc_i && wb_stb_i && !s.ack) begin
      if (wb_adr_i == ADDR_CTRL) begin
        next_s.dat = ctrl_word;
      end else if (wb_adr_i == ADDR_PRESET) begin
        next_s.dat = pre_word;
      end else begin
        next_s.dat = '0;
      end
    end

    // bus writes take effect on the edge that sees ack
    if (wr_take) begin
      if (wb_adr_i == ADDR_CTRL) begin
        next_s.sys_en = ctrl_new[CTRL_SYS_EN];
        next_s.alert_en = ctrl_new[CTRL_ALERT_EN];
        next_s.alert_rst = ctrl_new[CTRL_ALERT_RST];
      end else if (wb_adr_i == ADDR_PRESET) begin
        next_s.thr = pre_new[PRE_THR_LSB +: FIELD_W];
        next_s.run_preset = pre_new[PRE_RUN_LSB +: FIELD_W];
        next_s.frm_preset = pre_new[PRE_FRM_LSB +: FIELD_W];
      end
    end

    // monitor sequencing
    case (s.st)
      BSS_IDLE: begin
        next_s.frame_open = 1'b0;
        next_s.frame_cnt = '0;
        if (s.sys_en) begin
          next_s.st = BSS_ARMED;
        end
      end
      BSS_ARMED: begin
        if (!s.sys_en) begin
          next_s.st = BSS_IDLE;
        end else if (integration_run_sync_i) begin
          next_s.st = BSS_MON;
        end
      end
      BSS_MON: begin
        if (!s.sys_en) begin
          next_s.st = BSS_IDLE;
        end else if (frame_sync_i) begin
          next_s.frame_open = 1'b1;
          if (frame_end) begin
            if (!det_hit) begin
              next_s.frame_cnt = '0;
            end else if (fire) begin
              next_s.frame_cnt = '0;
            end else begin
              next_s.frame_cnt = cnt_inc[FIELD_W-1:0];
            end
          end
        end
      end
      default: begin
        next_s.st = BSS_IDLE;
      end
    endcase

    // safing action
    if (fire) begin
      next_s.alert_flag = 1'b1;
      if (s.alert_en) begin
        next_s.cathode_safe = 1'b1;
      end
    end

    // alert reset holds detection at power-up state, settings kept
    if (s.alert_rst) begin
      next_s.st = BSS_IDLE;
      next_s.frame_open = 1'b0;
      next_s.frame_cnt = '0;
      next_s.alert_flag = 1'b0;
      next_s.cathode_safe = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= RESET_ST;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.dat;
  assign cathode_safe_o = s.cathode_safe;
  assign alert_flag_o = s.alert_flag;
  assign monitor_active_o = (s.st == BSS_MON);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_fire_sets_flag: assert property (
    @(posedge clk_i) disable iff (rst_i)
    fire |=> alert_flag_o)
    else $error("detection did not set alert flag");

  a_fire_safes_cathode: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (fire && s.alert_en) |=> cathode_safe_o)
    else $error("enabled detection did not safe cathode");

  a_cathode_needs_enable: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(cathode_safe_o) |-> $past(s.alert_en) && $past(fire))
    else $error("cathode safed without enable or detection");

  a_flag_sticky_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (alert_flag_o && !s.alert_rst) |=> alert_flag_o)
    else $error("alert flag dropped without alert reset");

  a_alert_reset_clears: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s.alert_rst |=> !alert_flag_o && !cathode_safe_o && (s.st == BSS_IDLE))
    else $error("alert reset left alert state set");

  a_settings_kept: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s.alert_rst && !wr_take) |=> $stable(s.thr) && $stable(s.run_preset)
    && $stable(s.frm_preset))
    else $error("alert reset disturbed settings");

  a_start_on_integration_run_sync: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(monitor_active_o) |-> $past(integration_run_sync_i) && $past(s.st == BSS_ARMED))
    else $error("monitoring started without integration-run sync");

  a_frame_cnt_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (frame_end && !det_hit) |=> (s.frame_cnt == '0))
    else $error("frame counter kept after empty frame");

  a_fire_needs_frames: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(alert_flag_o) |-> $past(frame_end) && $past(det_hit)
    && ({1'b0, $past(s.frame_cnt)} + 9'h001 >= {1'b0, $past(s.frm_preset)}))
    else $error("safing without enough qualifying frames");

  a_ack_single: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle long");

endmodule

/* File: design/bss_pkg.sv */
package bss_pkg;

  // ----------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CTRL_BUS_HZ = 512;
  localparam int unsigned CTRL_BUS_BIT_CYCLES = CLK_HZ / CTRL_BUS_HZ;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_PRESET = 4'h4;

  // control / status word
  localparam int unsigned CTRL_SYS_EN = 0;
  localparam int unsigned CTRL_ALERT_EN = 1;
  localparam int unsigned CTRL_ALERT_RST = 2;
  localparam int unsigned STAT_FLAG = 8;
  localparam int unsigned STAT_CATHODE = 9;
  localparam int unsigned STAT_MONITOR = 10;
  localparam int unsigned STAT_FCNT_LSB = 16;

  // preset word
  localparam int unsigned PRE_THR_LSB = 0;
  localparam int unsigned PRE_RUN_LSB = 8;
  localparam int unsigned PRE_FRM_LSB = 16;

  // ----------------------------------------------------------------
  // field widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned FIELD_W = 8;
  localparam int unsigned THR_USED = 5;
  localparam logic [7:0] THR_RST = 8'hFF;
  localparam logic [7:0] RUN_RST = 8'h08;
  localparam logic [7:0] FRM_RST = 8'h03;

  // ----------------------------------------------------------------
  // monitor states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BSS_IDLE = 2'b00,
    BSS_ARMED = 2'b01,
    BSS_MON = 2'b10
  } bss_state_t;

  // byte-lane merge of a bus write into a register word
  function automatic logic [31:0] bss_merge(input logic [31:0] old_w,
                                            input logic [31:0] wr_w,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = wr_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

endpackage

/* File: design/bss_run_detect.sv */
`timescale 1ns/1ps
module bss_run_detect import bss_pkg::*; #(
  parameter int PIX_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic pix_valid_i,
  input wire logic [PIX_W-1:0] pix_i,
  input wire logic [FIELD_W-1:0] thr_i,
  input wire logic [FIELD_W-1:0] preset_i,
  output logic [FIELD_W-1:0] run_o,
  output logic hit_o
);

  typedef struct packed {
    logic [FIELD_W-1:0] run;
    logic hit;
  } bss_run_st_t;

  bss_run_st_t s;
  bss_run_st_t next_s;
  logic above;

  // ----------------------------------------------------------------
  // run counting
  // ----------------------------------------------------------------
  always_comb begin
    above = pix_i[PIX_W-1 -: THR_USED] > thr_i[FIELD_W-1 -: THR_USED];
    next_s = s;
    if (clear_i) begin
      next_s.run = '0;
      next_s.hit = 1'b0;
    end else if (pix_valid_i) begin
      if (above) begin
        if (s.run != '1) begin
          next_s.run = s.run + 8'h01;
        end
        if (({1'b0, s.run} + 9'h001) >= {1'b0, preset_i}) begin
          next_s.hit = 1'b1;
        end
      end else begin
        next_s.run = '0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign run_o = s.run;
  assign hit_o = s.hit;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_run_low_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (pix_valid_i && !above && !clear_i) |=> (run_o == '0))
    else $error("run count not cleared by low pixel");

  a_run_sync_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    clear_i |=> (run_o == '0) && !hit_o)
    else $error("run state not cleared at frame start");

  a_run_hit_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (pix_valid_i && above && !clear_i && ({1'b0, run_o} + 9'h001 >= {1'b0, preset_i}))
    |=> hit_o)
    else $error("qualifying run not flagged");

endmodule

/* File: tb/bss_cam_model.sv */
`timescale 1ns/1ps
module bss_cam_model (
  output logic pix_valid_o,
  output logic [7:0] pix_o,
  output logic frame_sync_o,
  output logic integration_run_sync_o,
  input wire logic clk_i
);
  // ----------------------------------------------------------------
  // camera video source
  // ----------------------------------------------------------------
  initial begin
    pix_valid_o = 1'b0;
    pix_o = 8'h00;
    frame_sync_o = 1'b0;
    integration_run_sync_o = 1'b0;
  end

  // one frame: sync pulse, eight valid pixels, hot ones first
  task automatic send_frame(input int hot, input logic [7:0] amp);
    @(posedge clk_i);
    frame_sync_o <= 1'b1;
    pix_o <= ~pix_o;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      frame_sync_o <= 1'b0;
      pix_valid_o <= 1'b1;
      pix_o <= (i < hot) ? amp : 8'h10;
    end
    @(posedge clk_i);
    pix_valid_o <= 1'b0;
    pix_o <= ~pix_o;
  endtask

  // single integration-run pulse
  task automatic integration_run_sync_pulse();
    @(posedge clk_i);
    integration_run_sync_o <= 1'b1;
    @(posedge clk_i);
    integration_run_sync_o <= 1'b0;
  endtask
endmodule

/* File: tb/bss_monitor_tb.sv */
`timescale 1ns/1ps
module bss_monitor_tb import bss_pkg::*;;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic pix_valid;
  logic [7:0] pix;
  logic frame_sync;
  logic integration_run_sync;
  logic cathode_safe_o;
  logic alert_flag_o;
  logic monitor_active_o;
  int miscompares = 0;
  int samples_checked = 0;

  always #50 clk_i = ~clk_i;

  bss_monitor #(.PIX_W(8)) bss_monitor_i (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(sel),
    .wb_dat_i(dat_w),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .pix_valid_i(pix_valid),
    .pix_i(pix),
    .frame_sync_i(frame_sync),
    .integration_run_sync_i(integration_run_sync),
    .cathode_safe_o(cathode_safe_o),
    .alert_flag_o(alert_flag_o),
    .monitor_active_o(monitor_active_o)
  );

  bss_cam_model bss_cam_model_i (
    .pix_valid_o(pix_valid),
    .pix_o(pix),
    .frame_sync_o(frame_sync),
    .integration_run_sync_o(integration_run_sync),
    .clk_i(clk_i)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // classic wishbone cycle; reads compare against exp
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                    input logic [31:0] d, input logic [31:0] exp);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat_w <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    chk({31'h0, wb_ack_o}, 32'h1);
    if (!w) begin
      chk(wb_dat_o, exp);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // output pins as {monitor, cathode, flag}
  task automatic pins(input logic [2:0] exp);
    @(negedge clk_i);
    chk({29'h0, monitor_active_o, cathode_safe_o, alert_flag_o}, {29'h0, exp});
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADDR_CTRL, 4'h0, 32'h0, 32'h0000_0000);
    wb(1'b0, ADDR_PRESET, 4'h0, 32'h0, 32'h0003_08FF);
    wb(1'b1, 4'h8, 4'hF, 32'hFFFF_FFFF, 32'h0);
    wb(1'b0, 4'h8, 4'h0, 32'h0, 32'h0000_0000);
    wb(1'b0, ADDR_CTRL, 4'h0, 32'h0, 32'h0000_0000);
    $display("test reset_map done");

    wb(1'b1, ADDR_PRESET, 4'hF, 32'h0002_0280, 32'h0);
    wb(1'b0, ADDR_PRESET, 4'h0, 32'h0, 32'h0002_0280);
    wb(1'b1, ADDR_CTRL, 4'hF, 32'h0000_0003, 32'h0);
    repeat (5) @(posedge clk_i);
    pins(3'b000);
    bss_cam_model_i.integration_run_sync_pulse();
    pins(3'b100);
    bss_cam_model_i.send_frame(2, 8'h88);
    bss_cam_model_i.send_frame(1, 8'h88);
    bss_cam_model_i.send_frame(3, 8'h87);
    bss_cam_model_i.send_frame(2, 8'h88);
    bss_cam_model_i.send_frame(2, 8'h88);
    pins(3'b100);
    wb(1'b0, ADDR_CTRL, 4'h0, 32'h0, 32'h0001_0403);
    bss_cam_model_i.send_frame(0, 8'h00);
    pins(3'b111);
    wb(1'b0, ADDR_CTRL, 4'h0, 32'h0, 32'h0000_0703);
    wb(1'b1, ADDR_CTRL, 4'h6, 32'hFFFF_FF00, 32'h0);
    wb(1'b0, ADDR_CTRL, 4'h0, 32'h0, 32'h0000_0703);
    $display("test detect done");

    wb(1'b1, ADDR_CTRL, 4'h1, 32'h0000_0007, 32'h0);
    @(posedge clk_i);
    pins(3'b000);
    bss_cam_model_i.integration_run_sync_pulse();
    bss_cam_model_i.send_frame(2, 8'h88);
    bss_cam_model_i.send_frame(2, 8'h88);
    bss_cam_model_i.send_frame(2, 8'h88);
    pins(3'b000);
    wb(1'b0, ADDR_PRESET, 4'h0, 32'h0, 32'h0002_0280);
    wb(1'b1, ADDR_CTRL, 4'h1, 32'h0000_0001, 32'h0);
    bss_cam_model_i.integration_run_sync_pulse();
    pins(3'b100);
    bss_cam_model_i.send_frame(2, 8'h88);
    bss_cam_model_i.send_frame(2, 8'h88);
    bss_cam_model_i.send_frame(2, 8'h88);
    pins(3'b101);
    wb(1'b0, ADDR_CTRL, 4'h0, 32'h0, 32'h0000_0501);
    $display("test gated done");
    wrap_up();
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    $display("BAD t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    wrap_up();
  end
endmodule
